// ---- ccpu_chk.sv ----
/*
  port checker for ccpu_unit.
  assumes: bound to every ccpu_unit; one clock, sync active-low reset.
*/
`timescale 1ns/1ps
`include "ccpu_map.vh"
module ccpu_chk #(
  parameter AW = 8
)(
  input wire          aclk,
  input wire          aresetn,
  input wire [AW-1:0] s_axi_araddr,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire [31:0]   s_axi_rdata,
  input wire          s_axi_rvalid,
  input wire          s_axi_bvalid,
  input wire          s_axi_awready,
  input wire          s_axi_wready,
  input wire          unit_irq_flag,
  input wire          timer16_reset,
  input wire          adc_start,
  input wire          adc_enable,
  input wire          timer8_clear,
  input wire          timer8_inc,
  input wire [7:0]    timer8_count,
  input wire [7:0]    timer8_period
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [AW-1:0] ra_r;
  always @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
  property p_ctl;
    s_axi_rvalid && ra_r[7:2] == `CCPU_IDX_CTRL |-> s_axi_rdata[31:6] == 0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control high bits set");
  property p_flg;
    s_axi_rvalid && ra_r[7:2] == `CCPU_IDX_FLAG
      |-> (s_axi_rdata & 32'hFFFFFFFB) == 32'h0;
  endproperty
  a_flg: assert property (p_flg) else $error("flag reg extra bit");
  property p_fall;
    $fell(unit_irq_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_fall: assert property (p_fall) else $error("flag cleared by hw");
  property p_trig;
    timer16_reset |-> unit_irq_flag;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger w/o flag");
  property p_adc;
    adc_start |-> timer16_reset && $past(adc_enable);
  endproperty
  a_adc: assert property (p_adc) else $error("stray adc start");
  property p_clr;
    timer8_clear |-> $past(timer8_inc && timer8_count == timer8_period);
  endproperty
  a_clr: assert property (p_clr) else $error("stray timer clear");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_b;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b: assert property (p_b) else $error("write taken while busy");
  c_trig: cover property (timer16_reset);
  c_clr: cover property (timer8_clear);
  c_fall: cover property ($fell(unit_irq_flag));
endmodule
bind ccpu_unit ccpu_chk #(.AW(AW)) u_chk (.*);

// ---- ccpu_map.vh ----
/*
  register indices, field positions, reset values and mode codes of the
  capture/compare/pulse-width unit.
  assumes: included by ccpu_unit.v; byte address = 4 * register index.
*/
// What this block does
// - mode 0000 turns the unit off and resets its internal state
// - modes 0100-0111 capture on fall, rise, 4th rise, 16th rise
// - modes 1000/1001 drive output high/low on match and set flag
// - mode 1010 sets only the flag on match, pin unchanged
// - mode 1011 sets flag, resets 16-bit timer, starts conversion
// - modes 11xx are pulse-width; control bits 5:4 are duty lsbs
// - control bits 7 and 6 always read zero
// - capture copies the 16-bit timer into the high and low bytes
// - capture sets flag bit 2; only software clears it
// - a new capture overwrites an unread value
// - pin level is sampled even when the pin is an output
// - prescaler cleared when off, not capturing, or in reset
// - switching prescale settings keeps the prescaler count
// - compare runs continuously; match acts and flags same cycle
// - clearing control forces the unit output latch low
// - special event reset never sets the timer overflow flag
// - capture/compare use 16-bit timer; pwm uses 8-bit timer, 10 bits
// - after period match: clear timer, set output unless the new duty is zero, latch duty
// - output cleared when latched duty equals extended 8-bit timer
// - in pulse-width mode the high byte is read-only duty buffer
// - duty beyond period never clears the output
`ifndef CCPU_MAP_VH
`define CCPU_MAP_VH

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define CCPU_IDX_FLAG     6'h0C
`define CCPU_IDX_LOW      6'h15
`define CCPU_IDX_HIGH     6'h16
`define CCPU_IDX_CTRL     6'h17

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define CCPU_FLAG_BIT     2
`define CCPU_CTRL_WMASK   8'h3F
`define CCPU_CTRL_RST     8'h00
`define CCPU_FLAG_RST     1'b0

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define CCPU_M_OFF        4'h0
`define CCPU_M_CAP_FALL   4'h4
`define CCPU_M_CAP_RISE   4'h5
`define CCPU_M_CAP_4      4'h6
`define CCPU_M_CAP_16     4'h7
`define CCPU_M_CMP_HIGH   4'h8
`define CCPU_M_CMP_LOW    4'h9
`define CCPU_M_CMP_SOFT   4'hA
`define CCPU_M_CMP_TRIG   4'hB

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define CCPU_RESP_OKAY    2'h0
`define CCPU_RESP_SLVERR  2'h2

`endif

// ---- ccpu_model.sv ----
/*
  far-side model: free 16-bit timer and 8-bit timer with 2-bit extension.
  assumes: the bench loads or holds the 16-bit timer; one clock aclk.
*/
`timescale 1ns/1ps
module ccpu_model (
  input  wire        aclk,
  input  wire        hold,
  input  wire        ld,
  input  wire [15:0] ld_v,
  input  wire        timer16_reset,
  input  wire [7:0]  timer8_period,
  output reg  [15:0] timer16_pair,
  output wire [7:0]  timer8_count,
  output wire [1:0]  timer8_low_bits,
  output wire        timer8_inc
);
  reg [9:0] q_r = 10'h000;
  initial timer16_pair = 16'h0000;
  assign timer8_count    = q_r[9:2];
  assign timer8_low_bits = q_r[1:0];
  assign timer8_inc      = &q_r[1:0];
  // synchronous timers only; a load beats the trigger
  always @(posedge aclk)
  begin
    if (ld)
      timer16_pair <= ld_v;
    else if (timer16_reset)
      timer16_pair <= 16'h0000;
    else if (!hold)
      timer16_pair <= timer16_pair + 16'h0001;
    q_r <= (timer8_inc && timer8_count == timer8_period) ? 10'h000
           : q_r + 10'h001;
  end
endmodule

// ---- ccpu_tb.sv ----
/*
  self-checking bench for ccpu_unit over axi4-lite.
  assumes: ccpu_model drives the timers; ccpu_chk is bound.
*/
`timescale 1ns/1ps
`include "ccpu_map.vh"
module tb;
  reg aclk = 1'b0, aresetn = 1'b0, event_pin_i = 1'b0, adc_enable = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hold = 1'b1, ld = 1'b0;
  reg [15:0] ld_v = 16'h0000, w;
  reg [7:0] timer8_period = 8'h07;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, timer8_inc, event_pin_o, unit_irq_flag;
  wire timer16_reset, adc_start, timer8_clear;
  wire [1:0] s_axi_bresp, s_axi_rresp, timer8_low_bits;
  wire [31:0] s_axi_rdata;
  wire [15:0] timer16_pair;
  wire [7:0] timer8_count;
  integer num_errors = 0, n_checks = 0, cyc = 0, seed = 32'h5d4b;
  integer i, h, c, n_trig = 0, n_adc = 0, hc [0:3];
  reg [31:0] rd;
  reg [1:0] rr;
  localparam [7:0] A_F = {`CCPU_IDX_FLAG, 2'b00};
  localparam [7:0] A_L = {`CCPU_IDX_LOW, 2'b00};
  localparam [7:0] A_H = {`CCPU_IDX_HIGH, 2'b00};
  localparam [7:0] A_C = {`CCPU_IDX_CTRL, 2'b00};
  ccpu_unit u_dut (.*);
  ccpu_model u_tmr (.*);
  always #12.5 aclk = ~aclk;
  // ---------------------------------------------------------------
  // helpers and expectations
  // ---------------------------------------------------------------
  function [7:0] adr(input integer j);
    adr = j == 0 ? A_F : j == 1 ? A_L : j == 2 ? A_H : A_C;
  endfunction
  function integer ncap(input integer j);
    ncap = j < 2 ? 1 : j == 2 ? 4 : 16;
  endfunction
  function [7:0] cmode(input integer j);
    cmode = j == 0 ? 8'h08 : j == 1 ? 8'h0A : j == 2 ? 8'h09 : 8'h0B;
  endfunction
  function [7:0] duty(input integer j);
    duty = j == 0 ? 8'h00 : j == 1 ? 8'h02 : j == 2 ? 8'h05 : 8'h09;
  endfunction
  task print_verdict;
  begin
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready)
    begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
      if (s_axi_bvalid) rr = s_axi_bresp;
      @(posedge aclk);
    end
  end
  endtask
  task rdr(input [7:0] a);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arvalid || s_axi_rready)
    begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      if (s_axi_rvalid) rd = s_axi_rdata;
      if (s_axi_rvalid) rr = s_axi_rresp;
      @(posedge aclk);
    end
  end
  endtask
  task pulse(input integer n);
    repeat (n)
    begin
      event_pin_i <= 1'b1; // pin held as an input while capturing
      repeat (6) @(posedge aclk);
      event_pin_i <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
  task tset(input [15:0] v);
  begin
    ld <= 1'b1;
    ld_v <= v;
    @(posedge aclk);
    ld <= 1'b0;
  end
  endtask
  task meas;
  begin
    repeat (64) @(posedge aclk);
    h = 0;
    c = 0;
    repeat (128)
    begin
      @(posedge aclk);
      h = h + event_pin_o;
      c = c + timer8_clear;
    end
  end
  endtask
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    n_trig = n_trig + timer16_reset;
    n_adc = n_adc + adc_start;
    // cut a hang short well above the expected run length
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      rdr(adr(i));
      chk(rd, 32'h0);
    end
    s_axi_wstrb <= 4'h0;
    wr(A_C, 8'hFF);
    rdr(A_C);
    chk(rd, 32'h0);
    s_axi_wstrb <= 4'hF;
    wr(A_C, 8'hFF);
    rdr(A_C);
    chk(rd, 32'h3F);
    rdr(8'h04);
    chk(rr, `CCPU_RESP_SLVERR);
    wr(8'h04, 8'h55);
    chk(rr, `CCPU_RESP_SLVERR);
    for (i = 0; i < 4; i = i + 1)
    begin
      rd = $random(seed);
      w = rd[15:0];
      wr(A_C, 8'h00);
      wr(A_C, 8'h04 + i);
      wr(A_F, 8'h00);
      tset(w);
      pulse(ncap(i) - 1);
      rdr(A_F);
      chk(rd, 32'h0);
      pulse(1);
      rdr(A_F);
      chk(rd, 32'h4);
      tset(~w);
      pulse(ncap(i));
      rdr(A_L);
      chk(rd, {24'h0, ~w[7:0]});
      rdr(A_H);
      chk(rd, {24'h0, ~w[15:8]});
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      rd = $random(seed);
      w = rd[15:0];
      tset(~w);
      wr(A_L, w[7:0]);
      wr(A_H, w[15:8]);
      wr(A_C, cmode(i));
      wr(A_F, 8'h00);
      tset(w);
      repeat (4) @(posedge aclk);
      chk(unit_irq_flag, 1'b1);
      chk(event_pin_o, i < 2);
    end
    chk(timer16_pair, 16'h0000);
    chk(n_trig != 0 && n_adc == n_trig, 1'b1);
    rdr(A_F);
    chk(rd, 32'h4);
    h = n_adc;
    i = n_trig;
    adc_enable <= 1'b0;
    tset(w);
    repeat (4) @(posedge aclk);
    chk(n_trig > i && n_adc == h, 1'b1);
    adc_enable <= 1'b1;
    wr(A_C, 8'h08);
    tset(w);
    repeat (4) @(posedge aclk);
    chk(event_pin_o, 1'b1);
    wr(A_C, 8'h00);
    chk(event_pin_o, 1'b0);
    wr(A_C, 8'h0C);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(A_L, duty(i));
      meas;
      hc[i] = h;
      chk(c, 128 / (4 * (timer8_period + 1)));
      rdr(A_H);
      chk(rd, {24'h0, duty(i)});
    end
    chk(hc[0], 0);
    chk(hc[2] - hc[1], 48);
    chk(hc[3], 128);
    wr(A_H, 8'hAA);
    rdr(A_H);
    chk(rd, 32'h09);
    wr(A_L, 8'h05);
    wr(A_C, 8'h3F);
    meas;
    chk(h - hc[2], 12);
    print_verdict;
  end
endmodule

// ---- ccpu_unit.v ----
/*
  capture/compare/pulse-width unit with an axi4-lite register slave.
  assumes: 16-bit and 8-bit timers live outside and are presented on
  ports; timer8_inc pulses on each 8-bit timer increment cycle; the pin
  level arrives asynchronously; one clock aclk, synchronous reset.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ccpu_map.vh"

module ccpu_unit #(
  parameter AW = 8
)(
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          event_pin_i,
  input  wire [15:0]   timer16_pair,
  input  wire [7:0]    timer8_count,
  input  wire [7:0]    timer8_period,
  input  wire [1:0]    timer8_low_bits,
  input  wire          timer8_inc,
  input  wire          adc_enable,
  output reg           event_pin_o,
  output reg           unit_irq_flag,
  output reg           timer16_reset,
  output reg           adc_start,
  output reg           timer8_clear
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]    ctrl_r;
  reg  [7:0]    low_r;
  reg  [7:0]    high_r;
  reg  [1:0]    duty_lsb_r;
  reg  [3:0]    psc_r;
  reg           s1_r;
  reg           s2_r;
  reg           s3_r;
  reg           lvl_r;
  reg           lvl_d_r;
  reg  [AW-1:0] awaddr_r;
  reg  [31:0]   wdata_r;
  reg  [3:0]    wstrb_r;
  reg           aw_have_r;
  reg           w_have_r;

  wire [3:0]    mode    = ctrl_r[3:0];
  wire          is_cap  = (mode[3:2] == 2'b01);
  wire          is_cmp  = (mode[3:2] == 2'b10);
  wire          is_pwm  = (mode[3:2] == 2'b11);
  wire          rise    = lvl_r & ~lvl_d_r;
  wire          fall    = ~lvl_r & lvl_d_r;

  // ---------------------------------------------------------------
  // capture event select
  // ---------------------------------------------------------------
  reg           cap_evt;
  always @*
  begin
    case (mode)
      `CCPU_M_CAP_FALL: cap_evt = fall;
      `CCPU_M_CAP_RISE: cap_evt = rise;
      `CCPU_M_CAP_4:    cap_evt = rise & (psc_r[1:0] == 2'h3);
      `CCPU_M_CAP_16:   cap_evt = rise & (psc_r == 4'hF);
      default:          cap_evt = 1'b0;
    endcase
  end

  wire          cap_hit = is_cap & cap_evt;
  // compare against the 16-bit timer, every cycle
  wire          cmp_hit = is_cmp & ({high_r, low_r} == timer16_pair);
  wire          per_end = is_pwm & timer8_inc &
                          (timer8_count == timer8_period);
  wire [9:0]    duty_now = {low_r, ctrl_r[5:4]};
  // duty above period is simply never reached
  wire          duty_hit = is_pwm &
                ({high_r, duty_lsb_r} == {timer8_count, timer8_low_bits});

  // ---------------------------------------------------------------
  // bus write decode
  // ---------------------------------------------------------------
  wire          do_wr  = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [5:0]    wr_idx = awaddr_r[7:2];
  wire          wr_b0  = do_wr & wstrb_r[0];
  wire          wr_ok  = (wr_idx == `CCPU_IDX_FLAG) |
                         (wr_idx == `CCPU_IDX_LOW)  |
                         (wr_idx == `CCPU_IDX_HIGH) |
                         (wr_idx == `CCPU_IDX_CTRL);
  wire          wr_ctrl = wr_b0 & (wr_idx == `CCPU_IDX_CTRL);
  wire          wr_flag = wr_b0 & (wr_idx == `CCPU_IDX_FLAG);
  wire          wr_low  = wr_b0 & (wr_idx == `CCPU_IDX_LOW);
  wire          wr_high = wr_b0 & (wr_idx == `CCPU_IDX_HIGH);

  // ---------------------------------------------------------------
  // pin synchroniser and filter
  // ---------------------------------------------------------------
  // pin read whatever its direction, so port writes can capture
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      lvl_r   <= 1'b0;
      lvl_d_r <= 1'b0;
    end
    else
    begin
      s1_r    <= event_pin_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      if (s2_r == s3_r)
        lvl_r <= s3_r;
      lvl_d_r <= lvl_r;
    end
  end

  // ---------------------------------------------------------------
  // control register and capture prescaler
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `CCPU_CTRL_RST;
      psc_r  <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wdata_r[7:0] & `CCPU_CTRL_WMASK;
      // prescale count survives a switch between capture modes
      // off is not capture, so off wipes the count too
      if (!is_cap)
        psc_r <= 4'h0;
      else if (rise)
        psc_r <= psc_r + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // capture/compare word
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_r  <= 8'h00;
      high_r <= 8'h00;
    end
    else if (cap_hit)
    begin
      // capture overwrites, unread or not
      low_r  <= timer16_pair[7:0];
      high_r <= timer16_pair[15:8];
    end
    else
    begin
      if (wr_low)
        low_r <= wdata_r[7:0];
      // duty buffer is read-only in pulse-width mode
      if (per_end)
        high_r <= low_r;
      else if (wr_high && !is_pwm)
        high_r <= wdata_r[7:0];
    end
  end

  // ---------------------------------------------------------------
  // two-bit duty latch
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
      duty_lsb_r <= 2'h0;
    else if (mode == `CCPU_M_OFF)
      duty_lsb_r <= 2'h0;
    else if (per_end)
      duty_lsb_r <= ctrl_r[5:4];
  end

  // ---------------------------------------------------------------
  // interrupt flag
  // ---------------------------------------------------------------
  // hardware sets win over a software clear
  always @(posedge aclk)
  begin
    if (!aresetn)
      unit_irq_flag <= `CCPU_FLAG_RST;
    else if (cap_hit || cmp_hit)
      unit_irq_flag <= 1'b1;
    else if (wr_flag)
      unit_irq_flag <= wdata_r[`CCPU_FLAG_BIT];
  end

  // ---------------------------------------------------------------
  // output latch
  // ---------------------------------------------------------------
  // 1010 and 1011 leave it alone
  always @(posedge aclk)
  begin
    if (!aresetn)
      event_pin_o <= 1'b0;
    else if (mode == `CCPU_M_OFF)
      event_pin_o <= 1'b0;
    else if (cmp_hit && mode == `CCPU_M_CMP_HIGH)
      event_pin_o <= 1'b1;
    else if (cmp_hit && mode == `CCPU_M_CMP_LOW)
      event_pin_o <= 1'b0;
    else if (per_end)
      event_pin_o <= (duty_now != 10'h000);
    else if (duty_hit)
      event_pin_o <= 1'b0;
  end

  // ---------------------------------------------------------------
  // timer pulses
  // ---------------------------------------------------------------
  // trigger resets the timer and, if adc_enable, starts conversion; no overflow flag
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer16_reset <= 1'b0;
      adc_start     <= 1'b0;
      timer8_clear  <= 1'b0;
    end
    else
    begin
      timer16_reset <= cmp_hit & (mode == `CCPU_M_CMP_TRIG);
      adc_start     <= cmp_hit & (mode == `CCPU_M_CMP_TRIG) &
                       adc_enable;
      timer8_clear  <= per_end;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= {AW{1'b0}};
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCPU_RESP_OKAY;
    end
    else
    begin
      // ready is offered one cycle ahead; each channel taken once
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `CCPU_RESP_OKAY : `CCPU_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  reg  [31:0]   rd_val;
  reg           rd_ok;
  always @*
  begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[7:2])
      `CCPU_IDX_FLAG: rd_val[`CCPU_FLAG_BIT] = unit_irq_flag;
      `CCPU_IDX_LOW:  rd_val[7:0] = low_r;
      `CCPU_IDX_HIGH: rd_val[7:0] = high_r;
      `CCPU_IDX_CTRL: rd_val[7:0] = ctrl_r & `CCPU_CTRL_WMASK;
      default:        rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CCPU_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `CCPU_RESP_OKAY : `CCPU_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
